// File: rtl/cocd_option_decoder.sv
// option word fetch, decode and register access block
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module cocd_option_decoder #(
    parameter int WDT_LONG_CYC  = cocd_pkg::WDT_LONG_CYC,
    parameter int WDT_SHORT_CYC = cocd_pkg::WDT_SHORT_CYC
) (
    input  wire logic                       i_clk_sys,   // 100 MHz
    input  wire logic                       i_reset,     // async, high
    input  wire logic                       i_clk_en,    // freeze when low
    input  wire cocd_pkg::cocd_avs_req_type i_avs,       // bus request
    output cocd_pkg::cocd_avs_rsp_type      o_avs,       // bus answer
    output logic [1:0]                      o_otp_addr,  // word index
    output logic                            o_otp_rd,    // array read
    input  wire logic [12:0]                i_otp_data,  // array word
    input  wire logic                       i_core_hold, // core stopped
    input  wire logic                       i_sleep,     // core asleep
    output cocd_pkg::cocd_cfg_type          o_cfg,       // settings
    output logic                            o_cfg_valid, // settings good
    output logic                            o_noise_on   // int filter on
);
    import cocd_pkg::*;

    typedef struct packed {
        cocd_state_type   state;
        logic [1:0]       idx;
        logic             otp_rd;
        logic             cfg_valid;
        cocd_cfg_type     cfg;
        logic             noise_on;
        cocd_avs_rsp_type avs;
    } cocd_top_type;

    cocd_top_type     st_reg;
    cocd_top_type     st_next;
    logic [OPT_W-1:0] word_q [NUM_WORDS];
    logic             fetch_load;

    // ========================================
    // option decode
    function automatic cocd_cfg_type decode(
        input logic [OPT_W-1:0] w0,
        input logic [OPT_W-1:0] w1,
        input logic [OPT_W-1:0] w2,
        input logic [OPT_W-1:0] w3
    );
        cocd_cfg_type c;
        logic [3:0]   osc;
        c   = '0;
        osc = w1[W1_OSC_HI:W1_OSC_LO];
        // pwm width
        c.pwm_8bit = w0[W0_PWM];
        // wake count only means something on the internal RC
        c.internal_rc_osc = (osc[3:1] == OSC_IRC);
        if (c.internal_rc_osc) begin
            c.wake_clocks = w0[W0_WAKE] ? WAKE_SHORT : WAKE_LONG;
        end
        // instruction cycle length
        c.instr_osc_periods = w0[W0_INSTR_PERIOD_SEL] ? IPER_FOUR : IPER_TWO;
        // low voltage reset thresholds
        c.lvr_code   = cocd_lvr_type'(w0[W0_LVR_HI:W0_LVR_LO]);
        c.lvr_enable = (c.lvr_code != LVR_OFF);
        unique case (c.lvr_code)
            LVR_2V7: begin
                c.lvr_reset_cv   = CV_270;
                c.lvr_release_cv = CV_290;
            end
            LVR_3V5: begin
                c.lvr_reset_cv   = CV_350;
                c.lvr_release_cv = CV_370;
            end
            LVR_4V0: begin
                c.lvr_reset_cv   = CV_400;
                c.lvr_release_cv = CV_420;
            end
            LVR_OFF: begin
                c.lvr_reset_cv   = '0;
                c.lvr_release_cv = '0;
            end
        endcase
        // shared pin role and watchdog
        c.reset_pin_is_reset = ~w0[W0_RSTPIN];
        c.watchdog_enable    = ~w0[W0_WDT_N];
        c.wdt_period_cyc = w2[W2_WDT_PS]
                         ? WDT_CYC_W'(WDT_LONG_CYC)
                         : WDT_CYC_W'(WDT_SHORT_CYC);
        // interrupt pin noise filter
        c.noise_pulse_periods =
            w0[W0_NOISE_PULSE_WIDTH_SEL] ? NOISE_LONG : NOISE_SHRT;
        c.low_crystal_32k_mode = (osc == OSC_LOW_CRYSTAL_32K_MODE);
        c.low_crystal_mode =
            (osc == OSC_LXT1) | c.low_crystal_32k_mode;
        c.noise_reject_enable =
            w0[W0_NRE] & ~c.low_crystal_mode;
        // any programmed protect bit locks the code
        c.code_protect = (w0[W0_PROT_HI:0] != PROT_OFF);
        // internal RC frequency
        c.rc_freq_sel = cocd_rc_type'(w1[W1_RC_HI:W1_RC_LO]);
        unique case (c.rc_freq_sel)
            RC_4M:  c.rc_freq_mhz = MHZ_4;
            RC_16M: c.rc_freq_mhz = MHZ_16;
            RC_8M:  c.rc_freq_mhz = MHZ_8;
            RC_1M:  c.rc_freq_mhz = MHZ_1;
        endcase
        c.customer_id = w3;
        return c;
    endfunction

    // ========================================
    // word holding registers, one per option word
    assign fetch_load = (st_reg.state == ST_FETCH) & st_reg.otp_rd;

    for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
        cocd_word_latch #(
            .WIDTH (OPT_W),
            .INIT  (WORD_ERASE)
        ) u_word (
            .i_clk_sys (i_clk_sys),
            .i_reset   (i_reset),
            .i_clk_en  (i_clk_en),
            .i_load    (fetch_load && (st_reg.idx == 2'(g))),
            .i_data    (i_otp_data),
            .o_word    (word_q[g])
        );
    end

    // ========================================
    // next state: fetch sequence, bus slave, filter gate
    always_comb begin
        logic        req;
        logic        commit;
        logic [31:0] rd;
        logic [1:0]  resp;
        req    = i_avs.read | i_avs.write;
        commit = 1'b0;
        rd     = '0;
        resp   = RESP_OKAY;
        st_next = st_reg;

        // read mux and decode of the address
        unique case (i_avs.address)
            REG_WORD0:  rd = 32'(word_q[0]);
            REG_WORD1:  rd = 32'(word_q[1]);
            REG_WORD2:  rd = 32'(word_q[2]);
            REG_WORD3:  rd = 32'(word_q[3]);
            REG_STATUS: rd = 32'({st_reg.state, st_reg.noise_on,
                                  st_reg.cfg_valid});
            REG_CTRL:   rd = '0;
            default:    resp = RESP_DECER;
        endcase

        // one wait cycle, then answer for one cycle
        st_next.avs.waitrequest = 1'b1;
        if (req && st_reg.avs.waitrequest) begin
            st_next.avs.waitrequest = 1'b0;
            st_next.avs.readdata    = i_avs.read ? rd : '0;
            st_next.avs.response    = resp;
        end
        commit = ~st_reg.avs.waitrequest & i_avs.write
               & (i_avs.address == REG_CTRL) & i_avs.byteenable[0]
               & i_avs.writedata[CTRL_LOAD];

        // word fetch, decode, then hold
        unique case (st_reg.state)
            ST_FETCH: begin
                if (st_reg.idx == 2'h3) begin
                    st_next.otp_rd = 1'b0;
                    st_next.state  = ST_DECODE;
                end else begin
                    st_next.idx = st_reg.idx + 2'h1;
                end
            end
            ST_DECODE: begin
                st_next.cfg = decode(word_q[0], word_q[1],
                                     word_q[2], word_q[3]);
                st_next.cfg_valid = 1'b1;
                st_next.state     = ST_RUN;
            end
            ST_RUN: begin
                // reload only while the core is held
                if (commit && i_core_hold) begin
                    st_next.state     = ST_FETCH;
                    st_next.idx       = '0;
                    st_next.otp_rd    = 1'b1;
                    st_next.cfg_valid = 1'b0;
                end
            end
            default: begin
                st_next.state     = ST_FETCH;
                st_next.idx       = '0;
                st_next.otp_rd    = 1'b1;
                st_next.cfg_valid = 1'b0;
            end
        endcase

        // filter gate follows sleep and crystal mode live
        st_next.noise_on = st_reg.cfg_valid
                         & st_reg.cfg.noise_reject_enable
                         & ~st_reg.cfg.low_crystal_32k_mode
                         & ~i_sleep;
    end

    // ========================================
    // state register
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_reg.state           <= ST_FETCH;
            st_reg.idx             <= '0;
            st_reg.otp_rd          <= 1'b1;
            st_reg.cfg_valid       <= 1'b0;
            st_reg.cfg             <= '0;
            st_reg.noise_on        <= 1'b0;
            st_reg.avs.waitrequest <= 1'b1;
            st_reg.avs.readdata    <= '0;
            st_reg.avs.response    <= RESP_OKAY;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign o_avs       = st_reg.avs;
    assign o_otp_addr  = st_reg.idx;
    assign o_otp_rd    = st_reg.otp_rd;
    assign o_cfg       = st_reg.cfg;
    assign o_cfg_valid = st_reg.cfg_valid;
    assign o_noise_on  = st_reg.noise_on;

    // ========================================
    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    // the reset term keeps the release edge, where the state still
    // shows the reset values, from starting a burst check
    sequence seq_fetch_burst;
        (!i_reset && i_clk_en && st_reg.state == ST_FETCH
         && st_reg.idx == 2'h0)
        ##1 i_clk_en [*3];
    endsequence

    sequence seq_bus_start;
        i_clk_en && (i_avs.read || i_avs.write)
        && st_reg.avs.waitrequest;
    endsequence

    sequence seq_decode;
        i_clk_en && st_reg.state == ST_DECODE;
    endsequence

    chk_fetch_burst: assert property (
        seq_fetch_burst |=> st_reg.state == ST_DECODE && !o_otp_rd)
        else $error("word fetch did not finish in four cycles");

    chk_pwm_width: assert property (
        seq_decode |=> o_cfg.pwm_8bit == $past(word_q[0][W0_PWM]))
        else $error("pwm width does not follow word 0");

    chk_wake_count: assert property (
        seq_decode |=> o_cfg.wake_clocks ==
            (!o_cfg.internal_rc_osc ? 6'h00 :
             $past(word_q[0][W0_WAKE]) ? WAKE_SHORT : WAKE_LONG))
        else $error("wake clock count decoded wrong");

    chk_instr_period: assert property (
        seq_decode |=> o_cfg.instr_osc_periods ==
            ($past(word_q[0][W0_INSTR_PERIOD_SEL]) ? IPER_FOUR : IPER_TWO))
        else $error("instruction period decoded wrong");

    chk_lvr_levels: assert property (
        o_cfg_valid |-> (o_cfg.lvr_enable == (o_cfg.lvr_code != LVR_OFF))
        && (o_cfg.lvr_code != LVR_2V7 || (o_cfg.lvr_reset_cv == CV_270
            && o_cfg.lvr_release_cv == CV_290))
        && (o_cfg.lvr_code != LVR_4V0 || o_cfg.lvr_reset_cv == CV_400))
        else $error("low voltage reset levels wrong");

    chk_reset_pin: assert property (
        seq_decode |=> o_cfg.reset_pin_is_reset
            == !$past(word_q[0][W0_RSTPIN]))
        else $error("shared pin role inverted");

    chk_wdt_enable: assert property (
        seq_decode |=> o_cfg.watchdog_enable
            == !$past(word_q[0][W0_WDT_N]))
        else $error("watchdog enable polarity wrong");

    chk_noise_width: assert property (
        seq_decode |=> o_cfg.noise_pulse_periods ==
            ($past(word_q[0][W0_NOISE_PULSE_WIDTH_SEL]) ? NOISE_LONG : NOISE_SHRT))
        else $error("noise pulse width decoded wrong");

    chk_noise_lxt: assert property (
        o_cfg.low_crystal_mode |-> !o_cfg.noise_reject_enable)
        else $error("noise filter enabled in low crystal mode");

    chk_noise_gate: assert property (
        i_clk_en && (i_sleep || o_cfg.low_crystal_32k_mode)
        |=> !o_noise_on)
        else $error("noise filter on in sleep or 32k mode");

    chk_protect: assert property (
        seq_decode |=> o_cfg.code_protect
            == ($past(word_q[0][W0_PROT_HI:0]) != PROT_OFF))
        else $error("code protection decoded wrong");

    chk_wdt_period: assert property (
        seq_decode |=> o_cfg.wdt_period_cyc == ($past(
            word_q[2][W2_WDT_PS]) ? WDT_CYC_W'(WDT_LONG_CYC)
                                  : WDT_CYC_W'(WDT_SHORT_CYC)))
        else $error("watchdog period decoded wrong");

    chk_rc_freq: assert property (
        o_cfg_valid |-> (o_cfg.rc_freq_sel != RC_4M
            || o_cfg.rc_freq_mhz == MHZ_4)
        && (o_cfg.rc_freq_sel != RC_16M || o_cfg.rc_freq_mhz == MHZ_16)
        && (o_cfg.rc_freq_sel != RC_1M || o_cfg.rc_freq_mhz == MHZ_1))
        else $error("internal rc frequency decoded wrong");

    chk_cfg_hold: assert property (
        o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg))
        else $error("settings changed while valid");

    chk_reload_gate: assert property (
        st_reg.state == ST_RUN && !i_core_hold |=> o_cfg_valid)
        else $error("settings dropped while core runs");

    chk_bus_answer: assert property (
        seq_bus_start |=> !o_avs.waitrequest ##1 o_avs.waitrequest)
        else $error("bus answer not one cycle after wait");

endmodule

// File: rtl/cocd_pkg.sv
// package: option word layout, decode values and register map
// How it works
// - Three 13-bit option words and one 13-bit id word sit apart.
// - Word 0 bit 12 picks PWM width: 0 is 10-bit, 1 is 8-bit.
// - In internal RC mode wake waits RC settle plus 32 (0) or 8 (1).
// - Word 0 bit 9 makes a cycle 2 oscillator periods (0) or 4 (1).
// - Reset level code 11 off, 10 2.7/2.9V, 01 3.5/3.7V, 00 4.0/4.2V.
// - Word 0 bit 6 at 0 makes the shared pin a low-active reset.
// - The watchdog enable bit turns it on at 0 and off at 1.
// - The noise width bit accepts 8 osc periods at 0 and 32 at 1.
// - Noise rejection follows its enable, but is off in low crystal.
// - Noise rejection is off in 32.768 kHz crystal mode and sleep.
// - A 0 in the protect field of word 0 turns code protection on.
// - The watchdog period bit picks about 18 ms (1) or 4.5 ms (0).
// - The internal RC runs at 4 MHz unless word 1 picks 16, 8 or 1.
// - The RC field maps 11 to 4, 10 to 16, 01 to 8, 00 to 1 MHz.
package cocd_pkg;

    // ========================================
    // option words
    localparam int          OPT_W      = 13;
    localparam int          NUM_WORDS  = 4;
    localparam logic [12:0] WORD_ERASE = 13'h1fff;
    localparam int          W0_PWM     = 12;
    localparam int          W0_WAKE    = 10;
    localparam int          W0_INSTR_PERIOD_SEL    = 9;
    localparam int          W0_LVR_HI  = 8;
    localparam int          W0_LVR_LO  = 7;
    localparam int          W0_RSTPIN  = 6;
    localparam int          W0_WDT_N   = 5;
    localparam int          W0_NOISE_PULSE_WIDTH_SEL    = 4;
    localparam int          W0_NRE     = 3;
    localparam int          W0_PROT_HI = 2;
    localparam int          W1_RC_HI   = 6;
    localparam int          W1_RC_LO   = 5;
    localparam int          W1_OSC_HI  = 4;
    localparam int          W1_OSC_LO  = 1;
    localparam int          W2_WDT_PS  = 3;
    localparam logic [2:0]  PROT_OFF   = 3'h7;
    localparam logic [2:0]  OSC_IRC    = 3'h1;
    localparam logic [3:0]  OSC_LXT1   = 4'h4;
    localparam logic [3:0]  OSC_LOW_CRYSTAL_32K_MODE   = 4'h6;

    // ========================================
    // decode values
    localparam logic [5:0]  WAKE_LONG  = 6'h20;
    localparam logic [5:0]  WAKE_SHORT = 6'h08;
    localparam logic [2:0]  IPER_TWO   = 3'h2;
    localparam logic [2:0]  IPER_FOUR  = 3'h4;
    localparam logic [5:0]  NOISE_SHRT = 6'h08;
    localparam logic [5:0]  NOISE_LONG = 6'h20;
    localparam logic [8:0]  CV_270     = 9'h10e;
    localparam logic [8:0]  CV_290     = 9'h122;
    localparam logic [8:0]  CV_350     = 9'h15e;
    localparam logic [8:0]  CV_370     = 9'h172;
    localparam logic [8:0]  CV_400     = 9'h190;
    localparam logic [8:0]  CV_420     = 9'h1a4;
    localparam logic [4:0]  MHZ_1      = 5'h01;
    localparam logic [4:0]  MHZ_4      = 5'h04;
    localparam logic [4:0]  MHZ_8      = 5'h08;
    localparam logic [4:0]  MHZ_16     = 5'h10;

    // ========================================
    // watchdog period in cycles of the 100 MHz clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int WDT_LONG_US   = 18000;
    localparam int WDT_SHORT_US  = 4500;
    localparam int WDT_LONG_CYC  = WDT_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_SHORT_CYC = WDT_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int WDT_CYC_W     = 21;

    // ========================================
    // register map, byte addresses
    localparam int          ADDR_W     = 5;
    localparam logic [4:0]  REG_WORD0  = 5'h00;
    localparam logic [4:0]  REG_WORD1  = 5'h04;
    localparam logic [4:0]  REG_WORD2  = 5'h08;
    localparam logic [4:0]  REG_WORD3  = 5'h0c;
    localparam logic [4:0]  REG_STATUS = 5'h10;
    localparam logic [4:0]  REG_CTRL   = 5'h14;
    localparam int          CTRL_LOAD  = 0;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_DECER = 2'h3;

    // ========================================
    // types
    typedef enum logic [1:0] {
        ST_FETCH  = 2'b00,
        ST_DECODE = 2'b01,
        ST_RUN    = 2'b11
    } cocd_state_type;

    typedef enum logic [1:0] {
        LVR_4V0 = 2'b00,
        LVR_3V5 = 2'b01,
        LVR_2V7 = 2'b10,
        LVR_OFF = 2'b11
    } cocd_lvr_type;

    typedef enum logic [1:0] {
        RC_1M  = 2'b00,
        RC_8M  = 2'b01,
        RC_16M = 2'b10,
        RC_4M  = 2'b11
    } cocd_rc_type;

    typedef struct packed {
        logic                 pwm_8bit;
        logic                 internal_rc_osc;
        logic [5:0]           wake_clocks;
        logic [2:0]           instr_osc_periods;
        cocd_lvr_type         lvr_code;
        logic                 lvr_enable;
        logic [8:0]           lvr_reset_cv;
        logic [8:0]           lvr_release_cv;
        logic                 reset_pin_is_reset;
        logic                 watchdog_enable;
        logic [WDT_CYC_W-1:0] wdt_period_cyc;
        logic [5:0]           noise_pulse_periods;
        logic                 noise_reject_enable;
        logic                 low_crystal_mode;
        logic                 low_crystal_32k_mode;
        logic                 code_protect;
        cocd_rc_type          rc_freq_sel;
        logic [4:0]           rc_freq_mhz;
        logic [OPT_W-1:0]     customer_id;
    } cocd_cfg_type;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [3:0]        byteenable;
        logic [31:0]       writedata;
    } cocd_avs_req_type;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
        logic [1:0]  response;
    } cocd_avs_rsp_type;

endpackage

// File: rtl/cocd_word_latch.sv
// one option word holding register, loaded by strobe
`timescale 1ns/1ns
module cocd_word_latch #(
    parameter int               WIDTH = 13,
    parameter logic [WIDTH-1:0] INIT  = '1
) (
    input  wire logic             i_clk_sys, // system clock
    input  wire logic             i_reset,   // async reset, high
    input  wire logic             i_clk_en,  // freezes state when low
    input  wire logic             i_load,    // capture strobe
    input  wire logic [WIDTH-1:0] i_data,    // word from the array
    output logic      [WIDTH-1:0] o_word     // held word
);
    import cocd_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } cocd_latch_type;

    cocd_latch_type st_reg;
    cocd_latch_type st_next;

    // take the word on the strobe
    always_comb begin
        st_next = st_reg;
        if (i_load) begin
            st_next.word = i_data;
        end
    end

    // erased value until first load
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_reg.word <= INIT;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_word = st_reg.word;
endmodule

// File: dv/cocd_option_decoder_bench.sv
// self-checking bench for the option word fetch and decode block
`timescale 1ns/1ns
module cocd_option_decoder_bench;
    import cocd_pkg::*;

    // ========================================
    // stimulus and observed signals
    logic             clk_sys;
    logic             reset;
    logic             clk_en;
    cocd_avs_req_type avs_req;
    cocd_avs_rsp_type avs_rsp;
    logic [1:0]       otp_addr;
    logic             otp_rd;
    logic [12:0]      otp_mem [4];
    logic [12:0]      otp_data;
    logic             core_hold;
    logic             sleep;
    cocd_cfg_type     cfg;
    logic             cfg_valid;
    logic             noise_on;
    int               err_total;
    int               checks_done;
    cocd_cfg_type     exp_cfg;
    logic [31:0]      rdat;
    logic [1:0]       rsp;

    // option array answers combinationally for the addressed word
    assign otp_data = otp_mem[otp_addr];

    cocd_option_decoder #(
        .WDT_LONG_CYC  (40),
        .WDT_SHORT_CYC (10)
    ) i_cocd_option_decoder (
        .i_clk_sys   (clk_sys),
        .i_reset     (reset),
        .i_clk_en    (clk_en),
        .i_avs       (avs_req),
        .o_avs       (avs_rsp),
        .o_otp_addr  (otp_addr),
        .o_otp_rd    (otp_rd),
        .i_otp_data  (otp_data),
        .i_core_hold (core_hold),
        .i_sleep     (sleep),
        .o_cfg       (cfg),
        .o_cfg_valid (cfg_valid),
        .o_noise_on  (noise_on)
    );

    // ========================================
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        err_total++;
        summarize();
    end

    // ========================================
    // shared tasks
    task automatic summarize();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] e,
                       input logic [127:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [4:0] a,
                       input logic [31:0] wd);
        @(posedge clk_sys);
        avs_req.read      <= rd;
        avs_req.write     <= !rd;
        avs_req.address   <= a;
        avs_req.writedata <= wd;
        avs_req.byteenable <= 4'hf;
        do begin
            @(posedge clk_sys);
        end while (avs_rsp.waitrequest !== 1'b0);
        rdat = avs_rsp.readdata;
        rsp  = avs_rsp.response;
        avs_req.read  <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    // settings for fully erased words in external crystal mode
    function automatic cocd_cfg_type base();
        cocd_cfg_type c;
        c = '0;
        c.pwm_8bit            = 1'b1;
        c.instr_osc_periods   = IPER_FOUR;
        c.lvr_code            = LVR_OFF;
        c.wdt_period_cyc      = 21'h00_0028;
        c.noise_pulse_periods = NOISE_LONG;
        c.noise_reject_enable = 1'b1;
        c.rc_freq_sel         = RC_4M;
        c.rc_freq_mhz         = MHZ_4;
        c.customer_id         = WORD_ERASE;
        return c;
    endfunction

    // program words, ask for a reload, wait for the new settings
    task automatic reload(input logic [12:0] w0, input logic [12:0] w1,
                          input logic [12:0] w2, input logic hold);
        otp_mem[0] = w0;
        otp_mem[1] = w1;
        otp_mem[2] = w2;
        core_hold <= hold;
        bus(1'b0, REG_CTRL, 32'h0000_0001);
        do begin
            @(posedge clk_sys);
        end while (cfg_valid !== 1'b1);
        repeat (2) @(posedge clk_sys);
    endtask

    // ========================================
    // scenarios
    task automatic t_all_zero();
        reload(13'h0000, 13'h0004, 13'h1ff7, 1'b1);
        exp_cfg = base();
        exp_cfg.pwm_8bit = 1'b0;
        exp_cfg.internal_rc_osc = 1'b1;
        exp_cfg.wake_clocks = WAKE_LONG;
        exp_cfg.instr_osc_periods = IPER_TWO;
        exp_cfg.lvr_code = LVR_4V0;
        exp_cfg.lvr_enable = 1'b1;
        exp_cfg.lvr_reset_cv = CV_400;
        exp_cfg.lvr_release_cv = CV_420;
        exp_cfg.reset_pin_is_reset = 1'b1;
        exp_cfg.watchdog_enable = 1'b1;
        exp_cfg.wdt_period_cyc = 21'h00_000a;
        exp_cfg.noise_pulse_periods = NOISE_SHRT;
        exp_cfg.noise_reject_enable = 1'b0;
        exp_cfg.code_protect = 1'b1;
        exp_cfg.rc_freq_sel = RC_1M;
        exp_cfg.rc_freq_mhz = MHZ_1;
        exp_cfg.customer_id = 13'h0a5c;
        chk("cfg zero words", exp_cfg, cfg);
        chk("noise on", 1'b0, noise_on);
    endtask

    task automatic t_irc_codes();
        reload(13'h1f7f, 13'h1fc5, 13'h1fff, 1'b1);
        exp_cfg = base();
        exp_cfg.internal_rc_osc = 1'b1;
        exp_cfg.wake_clocks = WAKE_SHORT;
        exp_cfg.lvr_code = LVR_2V7;
        exp_cfg.lvr_enable = 1'b1;
        exp_cfg.lvr_reset_cv = CV_270;
        exp_cfg.lvr_release_cv = CV_290;
        exp_cfg.rc_freq_sel = RC_16M;
        exp_cfg.rc_freq_mhz = MHZ_16;
        exp_cfg.customer_id = 13'h0a5c;
        chk("cfg code 10", exp_cfg, cfg);
        chk("noise on", 1'b1, noise_on);
        bus(1'b1, REG_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_000f, rdat);
        bus(1'b1, 5'h18, 32'h0000_0000);
        chk("unmapped resp", RESP_DECER, rsp);
        chk("unmapped data", 32'h0000_0000, rdat);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("noise in sleep", 1'b0, noise_on);
        sleep <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("noise awake", 1'b1, noise_on);
        // with the clock enable low, sleep must not reach the gate
        clk_en <= 1'b0;
        sleep  <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("noise frozen", 1'b1, noise_on);
        clk_en <= 1'b1;
        sleep  <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reload(13'h1eff, 13'h1fa5, 13'h1fff, 1'b1);
        exp_cfg.lvr_code = LVR_3V5;
        exp_cfg.lvr_reset_cv = CV_350;
        exp_cfg.lvr_release_cv = CV_370;
        exp_cfg.rc_freq_sel = RC_8M;
        exp_cfg.rc_freq_mhz = MHZ_8;
        chk("cfg code 01", exp_cfg, cfg);
        reload(13'h0000, 13'h0000, 13'h0000, 1'b0);
        chk("cfg held", exp_cfg, cfg);
    endtask

    task automatic t_crystal();
        reload(13'h1fff, 13'h1fec, 13'h1fff, 1'b1);
        exp_cfg = base();
        exp_cfg.noise_reject_enable = 1'b0;
        exp_cfg.low_crystal_mode = 1'b1;
        exp_cfg.low_crystal_32k_mode = 1'b1;
        exp_cfg.customer_id = 13'h0a5c;
        chk("cfg 32k crystal", exp_cfg, cfg);
        chk("noise 32k", 1'b0, noise_on);
        reload(13'h1ffe, 13'h1fe8, 13'h1fff, 1'b1);
        exp_cfg.low_crystal_32k_mode = 1'b0;
        exp_cfg.code_protect = 1'b1;
        chk("cfg low crystal", exp_cfg, cfg);
        chk("noise low crystal", 1'b0, noise_on);
    endtask

    // ========================================
    // main sequence
    initial begin
        err_total   = 0;
        checks_done = 0;
        reset       = 1'b1;
        clk_en      = 1'b1;
        avs_req     = '0;
        core_hold   = 1'b0;
        sleep       = 1'b0;
        for (int i = 0; i < 4; i++) begin
            otp_mem[i] = WORD_ERASE;
        end
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("cfg erased", base(), cfg);
        chk("valid", 1'b1, cfg_valid);
        otp_mem[3] = 13'h0a5c;
        t_all_zero();
        t_irc_codes();
        t_crystal();
        bus(1'b1, REG_WORD3, 32'h0000_0000);
        chk("word 3 id", 32'h0000_0a5c, rdat);
        summarize();
    end
endmodule
